//--- rrx_regs.vh
`ifndef RRX_REGS_VH
`define RRX_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Avalon register byte offsets
`define RRX_OFF_CTRL        6'h00
`define RRX_OFF_ACC         6'h04
`define RRX_OFF_STATUS      6'h08
`define RRX_OFF_BANK        6'h0c
`define RRX_OFF_ACC_SH      6'h10
`define RRX_OFF_STATUS_SH   6'h14
`define RRX_OFF_BANK_SH     6'h18
`define RRX_OFF_IRQ_EN      6'h1c
`define RRX_OFF_STATE       6'h20

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define RRX_CTRL_EXT_BIT    0
`define RRX_CTRL_PRIO_BIT   1
`define RRX_ST_C_BIT        0
`define RRX_ST_Z_BIT        2
`define RRX_ST_N_BIT        4
`define RRX_IRQ_HI_BIT      7
`define RRX_IRQ_LO_BIT      6

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RRX_RST_CTRL        2'h0
`define RRX_RST_BYTE        8'h00
`define RRX_RST_STATUS      5'h00
`define RRX_RST_BANK        4'h0
`define RRX_RST_IRQ_EN      2'h0

////////////////////////////////////////////////////////////////////////////////
// Opcodes
`define RRX_OP_RETURN_FROM_INTERRUPT_OP       15'h0008
`define RRX_OP_RETURN       15'h0009
`define RRX_OP_RETURN_WITH_LITERAL_OP        8'h0c
`define RRX_OP_ROTATE       6'h0d
`define RRX_ACCESS_LIMIT    8'h5f
`define RRX_ACCESS_HIGH     4'hf

////////////////////////////////////////////////////////////////////////////////
// Instruction classes
`define RRX_CLS_NONE        3'h0
`define RRX_CLS_RETURN_FROM_INTERRUPT_OP      3'h1
`define RRX_CLS_RETURN      3'h2
`define RRX_CLS_RETURN_WITH_LITERAL_OP       3'h3
`define RRX_CLS_ROTATE      3'h4

////////////////////////////////////////////////////////////////////////////////
// Quarter phases of one instruction cycle, one clock each
`define RRX_Q1              2'h0
`define RRX_Q2              2'h1
`define RRX_Q3              2'h2
`define RRX_Q4              2'h3

`endif

//--- rrx_rotate.v
`default_nettype none

module rrx_rotate (
    // Operand
    input  wire [7:0] data_in,
    input  wire       carry_in,
    // Result
    output wire [7:0] result_out,
    output wire       carry_out,
    output wire       neg_out,
    output wire       zero_out
);

    genvar i;
    generate
        for (i = 1; i < 8; i = i + 1) begin : g_shift
            assign result_out[i] = data_in[i-1]; // [RQ10]
        end
    endgenerate

    assign result_out[0] = carry_in;    // [RQ10]
    assign carry_out     = data_in[7];  // [RQ10]
    assign neg_out       = result_out[7];
    assign zero_out      = (result_out == 8'h00);

endmodule // rrx_rotate

`default_nettype wire

//--- rrx_exec.v
// Functional notes
// RQ1: Interrupt return pops stack into program counter
// RQ2: Interrupt return sets applicable global enable
// RQ3: Fast interrupt return restores W, status, bank
// RQ4: Interrupt return two cycles, pop in Q4
// RQ5: Returns never touch program counter latches
// RQ6: Literal return loads low byte into W
// RQ7: Literal return pops, no flags, two cycles
// RQ8: Subroutine return pops, no flags, enables kept
// RQ9: Fast subroutine return restores W, status, bank
// RQ10: Rotate left through carry, bit7 to carry
// RQ11: Destination bit picks W or file register
// RQ12: Access bit picks access bank or bank
// RQ13: Extended set uses indexed offset below 96
// RQ14: Rotate one cycle; updates carry, negative, zero
// RQ15: Second return cycle is idle pipeline refill
`include "rrx_regs.vh"
`default_nettype none

module rrx_exec (
    // Clock and reset
    input  wire        core_clk_in,
    input  wire        nrst_in,
    // Instruction from fetch/decode
    input  wire [15:0] instr_in,
    input  wire        instr_valid_in,
    output wire        instr_ready_out,
    output wire [1:0]  q_phase_out,
    output wire        refill_out,
    // Return stack and program counter
    input  wire [20:0] stack_top_value_in,
    output wire        stack_pop_out,
    output wire        pc_load_out,
    output wire [20:0] pc_value_out,
    // Data memory port
    input  wire [11:0] index_base_in,
    input  wire [7:0]  file_rdata_in,
    output wire [11:0] file_addr_out,
    output wire        file_rd_out,
    output wire        file_wr_out,
    output wire [7:0]  file_wdata_out,
    // Interrupt service level
    input  wire        high_service_in,
    // Live core registers
    output wire [7:0]  accumulator_out,
    output wire [4:0]  status_out,
    output wire [3:0]  bank_select_register_out,
    output wire        global_irq_enable_out,
    output wire        peripheral_irq_enable_out,
    // Avalon-MM slave
    input  wire [5:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output wire [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function [2:0] rrx_decode;
        input [15:0] op;
        begin
            if (op[15:1] == `RRX_OP_RETURN_FROM_INTERRUPT_OP) begin
                rrx_decode = `RRX_CLS_RETURN_FROM_INTERRUPT_OP;
            end else if (op[15:1] == `RRX_OP_RETURN) begin
                rrx_decode = `RRX_CLS_RETURN;
            end else if (op[15:8] == `RRX_OP_RETURN_WITH_LITERAL_OP) begin
                rrx_decode = `RRX_CLS_RETURN_WITH_LITERAL_OP;
            end else if (op[15:10] == `RRX_OP_ROTATE) begin
                rrx_decode = `RRX_CLS_ROTATE;
            end else begin
                rrx_decode = `RRX_CLS_NONE;
            end
        end
    endfunction

    function [11:0] rrx_file_addr;
        input [7:0]  f;
        input        a;
        input        ext;
        input [3:0]  bank;
        input [11:0] base;
        begin
            if (a) begin
                rrx_file_addr = {bank, f};                          // [RQ12]
            end else if (ext && (f <= `RRX_ACCESS_LIMIT)) begin
                rrx_file_addr = base + {4'h0, f};                   // [RQ13]
            end else if (f <= `RRX_ACCESS_LIMIT) begin
                rrx_file_addr = {4'h0, f};                          // [RQ12]
            end else begin
                rrx_file_addr = {`RRX_ACCESS_HIGH, f};              // [RQ12]
            end
        end
    endfunction

    function rrx_is_return;
        input [2:0] cls;
        begin
            rrx_is_return = (cls == `RRX_CLS_RETURN_FROM_INTERRUPT_OP) || (cls == `RRX_CLS_RETURN) ||
                            (cls == `RRX_CLS_RETURN_WITH_LITERAL_OP);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    reg  [1:0]  q_reg;
    reg  [15:0] instr_reg;
    reg  [2:0]  cls_reg;
    reg         refill_reg;
    reg         stack_pop_reg;
    reg         pc_load_reg;
    reg  [20:0] pc_value_reg;
    reg  [11:0] file_addr_reg;
    reg         file_rd_reg;
    reg         file_wr_reg;
    reg  [7:0]  file_wdata_reg;
    reg  [7:0]  acc_reg;
    reg  [4:0]  status_reg;
    reg  [3:0]  bank_reg;
    reg  [7:0]  acc_sh_reg;
    reg  [4:0]  status_sh_reg;
    reg  [3:0]  bank_sh_reg;
    reg  [1:0]  ctrl_reg;
    reg  [1:0]  irq_en_reg;
    reg         ack_reg;
    reg  [31:0] rdata_reg;

    wire [7:0]  rot_result;
    wire        rot_carry;
    wire        rot_neg;
    wire        rot_zero;

    wire        fast_bit    = instr_reg[0];
    wire        dest_bit    = instr_reg[9];
    wire        do_exec     = (q_reg == `RRX_Q3);
    wire        bus_req     = avs_read_in | avs_write_in;
    wire        bus_wr      = avs_write_in & ack_reg & avs_byteenable_in[0];
    wire        fast_return = ((cls_reg == `RRX_CLS_RETURN_FROM_INTERRUPT_OP) || (cls_reg == `RRX_CLS_RETURN)) && fast_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Rotate datapath

    rrx_rotate i_rrx_rotate (
        .data_in    (file_rdata_in),
        .carry_in   (status_reg[`RRX_ST_C_BIT]),
        .result_out (rot_result),
        .carry_out  (rot_carry),
        .neg_out    (rot_neg),
        .zero_out   (rot_zero)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Quarter sequencer and decode

    // No new instruction is taken while the pipeline refills after a return
    assign instr_ready_out = (q_reg == `RRX_Q1) & ~refill_reg; // [RQ15]

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q_reg      <= `RRX_Q1;
            instr_reg  <= 16'h0000;
            cls_reg    <= `RRX_CLS_NONE;
            refill_reg <= 1'b0;
        end else begin
            q_reg <= q_reg + 2'h1;
            case (q_reg)
                `RRX_Q1: begin
                    if (instr_valid_in && !refill_reg) begin
                        instr_reg <= instr_in;
                        cls_reg   <= rrx_decode(instr_in);
                    end else begin
                        cls_reg   <= `RRX_CLS_NONE;                 // [RQ15]
                    end
                end
                `RRX_Q4: begin
                    // Returns take a second, empty cycle
                    refill_reg <= rrx_is_return(cls_reg);            // [RQ4] [RQ7] [RQ8] [RQ15]
                    cls_reg    <= `RRX_CLS_NONE;
                end
                default: begin
                    refill_reg <= refill_reg;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stack pop and program counter load in Q4 of the first cycle

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stack_pop_reg <= 1'b0;
            pc_load_reg   <= 1'b0;
            pc_value_reg  <= 21'h000000;
        end else begin
            stack_pop_reg <= do_exec && rrx_is_return(cls_reg);     // [RQ1] [RQ7] [RQ8]
            pc_load_reg   <= do_exec && rrx_is_return(cls_reg);     // [RQ4]
            if (do_exec && rrx_is_return(cls_reg)) begin
                // Only the counter itself; the upper/high latches stay with their owner
                pc_value_reg <= stack_top_value_in;                  // [RQ1] [RQ5]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data memory: read in Q2, write in Q4

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            file_addr_reg  <= 12'h000;
            file_rd_reg    <= 1'b0;
            file_wr_reg    <= 1'b0;
            file_wdata_reg <= 8'h00;
        end else begin
            file_rd_reg <= 1'b0;
            file_wr_reg <= 1'b0;
            if ((q_reg == `RRX_Q1) && instr_valid_in && !refill_reg &&
                (rrx_decode(instr_in) == `RRX_CLS_ROTATE)) begin
                file_addr_reg <= rrx_file_addr(instr_in[7:0], instr_in[8], ctrl_reg[`RRX_CTRL_EXT_BIT],
                                               bank_reg, index_base_in); // [RQ12] [RQ13]
                file_rd_reg   <= 1'b1;                              // [RQ14]
            end
            if (do_exec && (cls_reg == `RRX_CLS_ROTATE) && dest_bit) begin
                file_wr_reg    <= 1'b1;                             // [RQ11] [RQ14]
                file_wdata_reg <= rot_result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Working, status and bank registers; the core wins over a bus write

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_reg    <= `RRX_RST_BYTE;
            status_reg <= `RRX_RST_STATUS;
            bank_reg   <= `RRX_RST_BANK;
        end else if (do_exec && fast_return) begin
            acc_reg    <= acc_sh_reg;                               // [RQ3] [RQ9]
            status_reg <= status_sh_reg;
            bank_reg   <= bank_sh_reg;
        end else if (do_exec && (cls_reg == `RRX_CLS_RETURN_WITH_LITERAL_OP)) begin
            acc_reg    <= instr_reg[7:0];                           // [RQ6] [RQ7]
        end else if (do_exec && (cls_reg == `RRX_CLS_ROTATE)) begin
            if (!dest_bit) begin
                acc_reg <= rot_result;                              // [RQ11]
            end
            status_reg[`RRX_ST_C_BIT] <= rot_carry;                 // [RQ10] [RQ14]
            status_reg[`RRX_ST_N_BIT] <= rot_neg;                   // [RQ14]
            status_reg[`RRX_ST_Z_BIT] <= rot_zero;                  // [RQ14]
        end else if (bus_wr) begin
            case (avs_address_in)
                `RRX_OFF_ACC: begin
                    acc_reg <= avs_writedata_in[7:0];
                end
                `RRX_OFF_STATUS: begin
                    status_reg <= avs_writedata_in[4:0];
                end
                `RRX_OFF_BANK: begin
                    bank_reg <= avs_writedata_in[3:0];
                end
                default: begin
                    bank_reg <= bank_reg;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shadow copies and control, written by software only

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_sh_reg    <= `RRX_RST_BYTE;
            status_sh_reg <= `RRX_RST_STATUS;
            bank_sh_reg   <= `RRX_RST_BANK;
            ctrl_reg      <= `RRX_RST_CTRL;
        end else if (bus_wr) begin
            case (avs_address_in)
                `RRX_OFF_ACC_SH: begin
                    acc_sh_reg <= avs_writedata_in[7:0];
                end
                `RRX_OFF_STATUS_SH: begin
                    status_sh_reg <= avs_writedata_in[4:0];
                end
                `RRX_OFF_BANK_SH: begin
                    bank_sh_reg <= avs_writedata_in[3:0];
                end
                `RRX_OFF_CTRL: begin
                    ctrl_reg <= avs_writedata_in[1:0];
                end
                default: begin
                    ctrl_reg <= ctrl_reg;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Global interrupt enables: a hardware set beats a software clear

    reg [1:0] irq_en_next;
    reg [1:0] irq_set;

    always @* begin
        irq_set = 2'h0;
        if (do_exec && (cls_reg == `RRX_CLS_RETURN_FROM_INTERRUPT_OP)) begin
            // Legacy scheme re-enables the global bit; priority scheme the level served
            if (!ctrl_reg[`RRX_CTRL_PRIO_BIT] || high_service_in) begin
                irq_set[1] = 1'b1;                                  // [RQ2]
            end else begin
                irq_set[0] = 1'b1;                                  // [RQ2]
            end
        end
        irq_en_next = irq_en_reg;
        if (bus_wr && (avs_address_in == `RRX_OFF_IRQ_EN)) begin
            irq_en_next = {avs_writedata_in[`RRX_IRQ_HI_BIT], avs_writedata_in[`RRX_IRQ_LO_BIT]};
        end
        // Subroutine and literal returns never reach the set terms
        irq_en_next = irq_en_next | irq_set;                         // [RQ8]
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_en_reg <= `RRX_RST_IRQ_EN;
        end else begin
            irq_en_reg <= irq_en_next;                              // [RQ4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait state on every access

    reg [31:0] rdata_next;

    always @* begin
        rdata_next = 32'h00000000;
        case (avs_address_in)
            `RRX_OFF_CTRL: begin
                rdata_next[1:0] = ctrl_reg;
            end
            `RRX_OFF_ACC: begin
                rdata_next[7:0] = acc_reg;
            end
            `RRX_OFF_STATUS: begin
                rdata_next[4:0] = status_reg;
            end
            `RRX_OFF_BANK: begin
                rdata_next[3:0] = bank_reg;
            end
            `RRX_OFF_ACC_SH: begin
                rdata_next[7:0] = acc_sh_reg;
            end
            `RRX_OFF_STATUS_SH: begin
                rdata_next[4:0] = status_sh_reg;
            end
            `RRX_OFF_BANK_SH: begin
                rdata_next[3:0] = bank_sh_reg;
            end
            `RRX_OFF_IRQ_EN: begin
                rdata_next[`RRX_IRQ_HI_BIT] = irq_en_reg[1];
                rdata_next[`RRX_IRQ_LO_BIT] = irq_en_reg[0];
            end
            `RRX_OFF_STATE: begin
                rdata_next[1:0] = q_reg;
                rdata_next[4:2] = cls_reg;
                rdata_next[5]   = refill_reg;
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
            if (avs_read_in && !ack_reg) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_waitrequest_out       = bus_req & ~ack_reg;
    assign avs_readdata_out          = rdata_reg;
    assign q_phase_out               = q_reg;
    assign refill_out                = refill_reg;
    assign stack_pop_out             = stack_pop_reg;
    assign pc_load_out               = pc_load_reg;
    assign pc_value_out              = pc_value_reg;
    assign file_addr_out             = file_addr_reg;
    assign file_rd_out               = file_rd_reg;
    assign file_wr_out               = file_wr_reg;
    assign file_wdata_out            = file_wdata_reg;
    assign accumulator_out           = acc_reg;
    assign status_out                = status_reg;
    assign bank_select_register_out  = bank_reg;
    assign global_irq_enable_out     = irq_en_reg[1];
    assign peripheral_irq_enable_out = irq_en_reg[0];

endmodule // rrx_exec

`default_nettype wire

//--- rrx_exec_checker.sv
`default_nettype none
module rrx_exec_checker (
    // Clock and reset
    input wire logic        core_clk_in,
    input wire logic        nrst_in,
    // Instruction side
    input wire logic [15:0] instr_in,
    input wire logic        instr_valid_in,
    input wire logic        instr_ready_out,
    input wire logic [1:0]  q_phase_out,
    input wire logic        refill_out,
    // Stack and data side
    input wire logic [20:0] stack_top_value_in,
    input wire logic        stack_pop_out,
    input wire logic        pc_load_out,
    input wire logic [20:0] pc_value_out,
    input wire logic [7:0]  file_rdata_in,
    input wire logic        file_wr_out,
    input wire logic        file_rd_out,
    input wire logic [7:0]  file_wdata_out,
    // Core registers
    input wire logic [7:0]  accumulator_out,
    input wire logic [4:0]  status_out,
    input wire logic        global_irq_enable_out,
    input wire logic        peripheral_irq_enable_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!nrst_in);
    wire take = (q_phase_out == 2'h0) && instr_valid_in && instr_ready_out;
    ////////////////////////////////////////////////////////////////////////////
    a_pop_in_q4: assert property (stack_pop_out |-> pc_load_out && q_phase_out == 2'h3)
        else $error("pop outside Q4 or without pc load");
    a_pc_from_top: assert property (stack_pop_out |-> pc_value_out == $past(stack_top_value_in))
        else $error("pc not loaded from stack top");
    a_refill_four: assert property (stack_pop_out |=> refill_out [*4] ##1 !refill_out)
        else $error("refill cycle length wrong");
    a_no_take_refill: assert property (refill_out |-> !instr_ready_out)
        else $error("ready during refill");
    a_rotate_dest: assert property (take && instr_in[15:10] == 6'h0d
        |=> file_rd_out ##2 file_wr_out == $past(instr_in[9], 3))
        else $error("rotate read or write timing wrong");
    a_rotate_carry: assert property (file_wr_out |-> file_wdata_out == {$past(file_rdata_in[6:0]),
        $past(status_out[0])} && status_out[0] == $past(file_rdata_in[7]))
        else $error("rotate result or carry wrong");
    a_return_flags: assert property (take && (instr_in == 16'h0012 || instr_in[15:8] == 8'h0c)
        |=> $stable(status_out) [*7])
        else $error("return changed status");
    a_return_irq: assert property (take && instr_in == 16'h0012
        |=> $stable({global_irq_enable_out, peripheral_irq_enable_out}) [*4])
        else $error("return changed interrupt enables");
    a_literal_w: assert property (take && instr_in[15:8] == 8'h0c
        |-> ##3 stack_pop_out && accumulator_out == $past(instr_in[7:0], 3))
        else $error("literal not in W at pop");
    a_irq_return: assert property (take && instr_in[15:1] == 15'h0008
        |-> ##3 stack_pop_out && (global_irq_enable_out || peripheral_irq_enable_out))
        else $error("interrupt return left enables clear");
endmodule // rrx_exec_checker

bind rrx_exec rrx_exec_checker i_rrx_exec_checker (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
    .instr_ready_out(instr_ready_out), .q_phase_out(q_phase_out), .refill_out(refill_out),
    .stack_top_value_in(stack_top_value_in), .stack_pop_out(stack_pop_out), .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out), .file_rdata_in(file_rdata_in), .file_wr_out(file_wr_out),
    .file_rd_out(file_rd_out), .file_wdata_out(file_wdata_out), .accumulator_out(accumulator_out),
    .status_out(status_out), .global_irq_enable_out(global_irq_enable_out),
    .peripheral_irq_enable_out(peripheral_irq_enable_out));
`default_nettype wire

//--- tb_rrx_exec.sv
`include "rrx_regs.vh"
`default_nettype none
module tb_rrx_exec;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] MSK = 64'hc00f1fff0f1fff03;
    logic        clk = 1'b0, nrst = 1'b0, ivalid = 1'b0, hisvc = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [20:0] stack_top_value = 21'h000000;
    logic [11:0] ibase = 12'h000;
    logic [7:0]  rdata = 8'h00;
    logic [5:0]  addr = 6'h00;
    logic [31:0] wdata = 32'h00000000;
    wire logic   rdy, refill, pop, pcl, frd, fwr, ge, pe, wreq;
    wire logic [1:0]  qph;
    wire logic [20:0] pcv;
    wire logic [11:0] fad;
    wire logic [7:0]  fwd, acc;
    wire logic [4:0]  st;
    wire logic [3:0]  bank_select_register;
    wire logic [31:0] rdat;
    logic [7:0]  mv [8];
    int          err_total = 0, n_tests = 0;
    always #4 clk = ~clk;
    rrx_exec i_rrx_exec (.core_clk_in(clk), .nrst_in(nrst), .instr_in(instr), .instr_valid_in(ivalid),
        .instr_ready_out(rdy), .q_phase_out(qph), .refill_out(refill), .stack_top_value_in(stack_top_value),
        .stack_pop_out(pop), .pc_load_out(pcl), .pc_value_out(pcv), .index_base_in(ibase),
        .file_rdata_in(rdata), .file_addr_out(fad), .file_rd_out(frd), .file_wr_out(fwr),
        .file_wdata_out(fwd), .high_service_in(hisvc), .accumulator_out(acc), .status_out(st),
        .bank_select_register_out(bank_select_register), .global_irq_enable_out(ge), .peripheral_irq_enable_out(pe),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq));
    ////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        k = 0;
        #1;
        while (wreq !== 1'b0 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 20) begin
            err_total++;
            give_verdict();
        end
        @(posedge clk);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Leaves the caller just after the taking edge, so Q2 is next
    task exec(input logic [15:0] op, input logic [7:0] fd, input logic [20:0] tv, input logic [11:0] ib);
        int k;
        @(posedge clk);
        instr <= op;
        ivalid <= 1'b1;
        rdata <= fd;
        stack_top_value <= tv;
        ibase <= ib;
        k = 0;
        #1;
        while (!(qph === 2'h0 && rdy === 1'b1) && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 40) begin
            err_total++;
            give_verdict();
        end
        @(posedge clk);
        ivalid <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        logic [31:0] q, w;
        logic [7:0] f, dt, r;
        logic [11:0] ib, ea;
        logic [20:0] tv;
        logic [15:0] op;
        void'($urandom(32'h5844));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 9; i++) begin
            bus(1'b0, (i == 8) ? 6'h3c : 6'(i * 4), 32'h0, q);
            check(q, 32'h0);
        end
        for (i = 0; i < 8; i++) begin
            w = $urandom;
            bus(1'b1, 6'(i * 4), w, q);
            bus(1'b0, 6'(i * 4), 32'h0, q);
            mv[i] = w[7:0] & MSK[i * 8 +: 8];
            check(q, {24'h0, mv[i]});
        end
        $display("test registers done");
        for (i = 0; i < 16; i++) begin
            f = i[3] ? 8'($urandom_range(95)) : 8'($urandom);
            dt = $urandom;
            ib = $urandom;
            mv[0] = {7'h0, i[2]};
            bus(1'b1, `RRX_OFF_CTRL, {24'h0, mv[0]}, q);
            exec({6'h0d, i[0], i[1], f}, dt, 21'h0, ib);
            ea = i[1] ? {mv[3][3:0], f} : (i[2] && f <= 8'h5f) ? ib + {4'h0, f} : {(f > 8'h5f) ? 4'hf : 4'h0, f};
            #1;
            check({frd, qph, fad}, {1'b1, 2'h1, ea});
            repeat (2) @(posedge clk);
            #1;
            r = {dt[6:0], mv[2][0]};
            check(fwr, i[0]);
            if (i[0])
                check(fwd, r);
            else
                mv[1] = r;
            mv[2][0] = dt[7];
            mv[2][2] = (r == 8'h00);
            mv[2][4] = r[7];
            check({st, acc}, {mv[2][4:0], mv[1]});
        end
        $display("test rotate done");
        for (i = 0; i < 8; i++) begin
            tv = $urandom;
            @(posedge clk);
            hisvc <= 1'($urandom);
            mv[0] = {6'h0, i[1], 1'b0};
            bus(1'b1, `RRX_OFF_CTRL, {24'h0, mv[0]}, q);
            mv[7] = 8'h00;
            bus(1'b1, `RRX_OFF_IRQ_EN, 32'h0, q);
            op = (i < 4) ? 16'h0010 | 16'(i[0]) : (i < 6) ? 16'h0012 | 16'(i[0]) : {8'h0c, 8'($urandom)};
            exec(op, 8'h00, tv, 12'h000);
            if (i < 6 && op[0]) begin
                mv[1] = mv[4];
                mv[2] = mv[5];
                mv[3] = mv[6];
            end
            if (i < 4)
                mv[7] = (mv[0][1] && !hisvc) ? 8'h40 : 8'h80;
            if (i >= 6)
                mv[1] = op[7:0];
            repeat (2) @(posedge clk);
            #1;
            check({pop, pcl, pcv}, {2'b11, tv});
            check({acc, st, bank_select_register}, {mv[1], mv[2][4:0], mv[3][3:0]});
            check({ge, pe}, mv[7][7:6]);
            @(posedge clk);
            #1;
            check({refill, rdy}, 2'b10);
            bus(1'b0, `RRX_OFF_STATE, 32'h0, q);
            check(q, 32'h21);
        end
        $display("test returns done");
        give_verdict();
    end
endmodule // tb_rrx_exec
`default_nettype wire
